// ### rtl/debug_link_map.vh
// Purpose: Offsets, field positions, reset values and counts of the debug link registers
// Assumes: Included by bare name from every design file of the block
// Notes: Definitions only
`ifndef DEBUG_LINK_MAP_VH
`define DEBUG_LINK_MAP_VH

// ==========================================================
// Register offsets
`define OFS_LINK_STATUS_REVISION 4'h0
`define OFS_LINK_ERROR_STATUS 4'h1
`define OFS_LINK_CONTROL_PRIMARY 4'h2
`define OFS_LINK_CONTROL_SECONDARY 4'h3
`define OFS_KEY_STATUS 4'h7
`define OFS_SYSTEM_RESET_REQUEST 4'h8
`define OFS_LINK_CLOCK_CONTROL 4'h9
`define OFS_SYSTEM_CONTROL 4'ha

// ==========================================================
// Field positions
`define REV_LSB 4
`define PRI_IBD_BIT 7
`define PRI_PARITY_DISABLE_BIT 5
`define PRI_DTD_BIT 4
`define PRI_RSD_BIT 3
`define SEC_NEG_ACK_DISABLE_BIT 4
`define SEC_CONTENTION_DETECT_DISABLE_BIT 3
`define SEC_LINKDIS_BIT 2
`define KEY_UROW_BIT 5
`define KEY_PROG_BIT 4
`define KEY_ERASE_BIT 3
`define SYS_USER_ROW_DONE_BIT 1
`define SYS_SYSTEM_CLOCK_REQUEST_BIT 0

// ==========================================================
// Reset values and codes
`define RST_CONTROL 8'h00
`define RST_CLKSEL 2'h3
`define RESET_CODE_ASSERT 8'h59
`define RESET_CODE_RELEASE 8'h00
`define GUARD_RESERVED 3'h7
`define GUARD_BASE_CYCLES 8'h80
`define ERR_NONE 3'h0
`define ERR_PARITY 3'h1
`define ERR_FRAME 3'h2
`define ERR_TIMEOUT 3'h3
`define ERR_START 3'h4
`define ERR_BUS 3'h6
`define ERR_CONTENTION 3'h7

// ==========================================================
// Timing counts
`define TIMEOUT_LINK_CYCLES 65536
`define INTER_BYTE_IDLE_BITS 8'h02

`endif

// ### rtl/link_gap_timer.v
// Purpose: Down counter that holds busy for a loaded number of ticks
// Assumes: tick_i and start_i are single-cycle strobes on clk_sys_i
// Notes: A start while busy reloads the count
`include "debug_link_map.vh"
module link_gap_timer #(
    parameter W = 8
) (
    input wire clk_sys_i,
    input wire rst_n_i,
    input wire ce_i,
    input wire clear_i,
    input wire start_i,
    input wire tick_i,
    input wire [W-1:0] count_i,
    output wire busy_o
);
    reg [W-1:0] cnt_r;

    // ==========================================================
    // Counter
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_r <= {W{1'b0}};
        end else if (ce_i) begin
            if (clear_i) begin
                cnt_r <= {W{1'b0}};
            end else if (start_i) begin
                cnt_r <= count_i;
            end else if (tick_i && cnt_r != {W{1'b0}}) begin
                cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
            end
        end
    end

    assign busy_o = (cnt_r != {W{1'b0}});
endmodule

// ### rtl/link_timeout_counter.v
// Purpose: Watches the wait for an access layer answer and flags a timeout
// Assumes: link_tick_i marks one link clock cycle
// Notes: Flags once per wait; a new wait restarts the count
`include "debug_link_map.vh"
module link_timeout_counter #(
    parameter LIMIT = `TIMEOUT_LINK_CYCLES,
    parameter W = 17
) (
    input wire clk_sys_i,
    input wire rst_n_i,
    input wire ce_i,
    input wire enable_i,
    input wire wait_i,
    input wire link_tick_i,
    output reg timeout_o
);
    reg [W-1:0] cnt_r;
    reg fired_r;
    wire [W-1:0] limit_w = LIMIT[W-1:0];

    // ==========================================================
    // Count link cycles while waiting
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_r <= {W{1'b0}};
            fired_r <= 1'b0;
            timeout_o <= 1'b0;
        end else if (ce_i) begin
            timeout_o <= 1'b0;
            if (!wait_i || !enable_i) begin
                cnt_r <= {W{1'b0}};
                fired_r <= 1'b0;
            end else if (link_tick_i && !fired_r) begin
                if (cnt_r == limit_w - {{(W-1){1'b0}}, 1'b1}) begin
                    fired_r <= 1'b1;
                    timeout_o <= 1'b1;
                end
                cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule

// ### rtl/debug_link_control_regs.v
// Purpose: Control and status registers of the single-wire program and debug link
// Assumes: Register port driven by the link's control space load and store decoder
// Notes: No processor port exists; the system reset output never resets this block
`include "debug_link_map.vh"

module debug_link_control_regs #(
    parameter [3:0] LINK_REVISION = 4'h2,
    parameter TIMEOUT_CYCLES = `TIMEOUT_LINK_CYCLES
) (
    input wire clk_sys_i,
    input wire rst_n_i,
    input wire ce_i,
    input wire csr_wr_i,
    input wire csr_rd_i,
    input wire [3:0] csr_addr_i,
    input wire [7:0] csr_wdata_i,
    output reg [7:0] csr_rdata_o,
    output reg csr_rvalid_o,
    input wire link_wake_i,
    input wire link_tick_i,
    input wire bit_tick_i,
    input wire parity_err_i,
    input wire frame_err_i,
    input wire start_err_i,
    input wire bus_err_i,
    input wire acc_wait_i,
    input wire rx_to_tx_i,
    input wire multi_load_i,
    input wire tx_byte_done_i,
    input wire ldst_busy_i,
    input wire tx_drive_i,
    input wire tx_level_i,
    input wire link_pin_i,
    input wire key_urow_ok_i,
    input wire key_prog_ok_i,
    input wire key_erase_ok_i,
    output wire link_enable_o,
    output wire tx_hold_o,
    output wire resp_sig_en_o,
    output reg nack_send_o,
    output wire system_reset_o,
    output wire [1:0] link_clock_select_o,
    output wire system_clock_request_o,
    output reg user_row_done_o,
    output reg urow_session_reset_o,
    output wire program_start_status_o
);
    // ==========================================================
    // State
    reg [7:0] ctrl_pri_r;
    reg [2:0] guard_sel_r;
    reg [7:0] ctrl_sec_r;
    reg [2:0] error_signature_r;
    reg user_row_key_status_r;
    reg mem_program_key_status_r;
    reg chip_erase_key_status_r;
    reg sys_reset_r;
    reg [1:0] link_clock_select_r;
    reg system_clock_request_r;
    reg program_start_r;
    reg link_disabled_r;
    reg pin_meta_r;
    reg pin_sync_r;
    reg [1:0] drive_dly_r;
    reg [1:0] level_dly_r;
    reg [7:0] rdata_nxt;
    reg [2:0] err_nxt;
    wire timeout_w;
    wire guard_busy_w;
    wire gap_busy_w;
    wire contention_w;
    wire wr_pri_w;
    wire wr_sec_w;
    wire wr_key_w;
    wire wr_rst_w;
    wire wr_clk_w;
    wire wr_sys_w;
    wire disable_w;
    wire reset_assert_w;
    wire reset_release_w;
    wire [7:0] guard_cycles_w;

    function wr_hit;
        input [3:0] addr;
        input [3:0] ofs;
        begin
            wr_hit = (addr == ofs);
        end
    endfunction

    // Only the link register port decodes these addresses
    assign wr_pri_w = csr_wr_i && wr_hit(csr_addr_i, `OFS_LINK_CONTROL_PRIMARY);
    assign wr_sec_w = csr_wr_i && wr_hit(csr_addr_i, `OFS_LINK_CONTROL_SECONDARY);
    assign wr_key_w = csr_wr_i && wr_hit(csr_addr_i, `OFS_KEY_STATUS);
    assign wr_rst_w = csr_wr_i && wr_hit(csr_addr_i, `OFS_SYSTEM_RESET_REQUEST);
    assign wr_clk_w = csr_wr_i && wr_hit(csr_addr_i, `OFS_LINK_CLOCK_CONTROL);
    assign wr_sys_w = csr_wr_i && wr_hit(csr_addr_i, `OFS_SYSTEM_CONTROL);
    assign disable_w = wr_sec_w && csr_wdata_i[`SEC_LINKDIS_BIT];
    assign reset_assert_w = wr_rst_w && csr_wdata_i == `RESET_CODE_ASSERT;
    assign reset_release_w = wr_rst_w && csr_wdata_i == `RESET_CODE_RELEASE;

    // ==========================================================
    // Pin synchroniser and contention check
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_meta_r <= 1'b1;
            pin_sync_r <= 1'b1;
            drive_dly_r <= 2'h0;
            level_dly_r <= 2'h3;
        end else if (ce_i) begin
            pin_meta_r <= link_pin_i;
            pin_sync_r <= pin_meta_r;
            drive_dly_r <= {drive_dly_r[0], tx_drive_i};
            level_dly_r <= {level_dly_r[0], tx_level_i};
        end
    end

    // Driven level is delayed to line up with the synchronised pin
    assign contention_w = !ctrl_sec_r[`SEC_CONTENTION_DETECT_DISABLE_BIT] && drive_dly_r[1] &&
                          (pin_sync_r != level_dly_r[1]);

    // ==========================================================
    // Timers
    link_timeout_counter #(
        .LIMIT(TIMEOUT_CYCLES),
        .W(17)
    ) u_timeout (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .enable_i(!ctrl_pri_r[`PRI_DTD_BIT] && !link_disabled_r),
        .wait_i(acc_wait_i),
        .link_tick_i(link_tick_i),
        .timeout_o(timeout_w)
    );

    assign guard_cycles_w = `GUARD_BASE_CYCLES >> guard_sel_r;

    link_gap_timer #(
        .W(8)
    ) u_guard (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .clear_i(disable_w),
        .start_i(rx_to_tx_i),
        .tick_i(link_tick_i),
        .count_i(guard_cycles_w),
        .busy_o(guard_busy_w)
    );

    link_gap_timer #(
        .W(8)
    ) u_gap (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .clear_i(disable_w),
        .start_i(tx_byte_done_i && multi_load_i && ctrl_pri_r[`PRI_IBD_BIT]),
        .tick_i(bit_tick_i),
        .count_i(`INTER_BYTE_IDLE_BITS),
        .busy_o(gap_busy_w)
    );

    assign tx_hold_o = guard_busy_w || gap_busy_w;

    // ==========================================================
    // Error signature
    always @* begin
        err_nxt = `ERR_NONE;
        if (contention_w) begin
            err_nxt = `ERR_CONTENTION;
        end else if (bus_err_i) begin
            err_nxt = `ERR_BUS;
        end else if (start_err_i) begin
            err_nxt = `ERR_START;
        end else if (timeout_w) begin
            err_nxt = `ERR_TIMEOUT;
        end else if (frame_err_i) begin
            err_nxt = `ERR_FRAME;
        end else if (parity_err_i && !ctrl_pri_r[`PRI_PARITY_DISABLE_BIT]) begin
            err_nxt = `ERR_PARITY;
        end
    end

    // ==========================================================
    // Register file
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_pri_r <= `RST_CONTROL;
            guard_sel_r <= 3'h0;
            ctrl_sec_r <= `RST_CONTROL;
            error_signature_r <= `ERR_NONE;
            user_row_key_status_r <= 1'b0;
            mem_program_key_status_r <= 1'b0;
            chip_erase_key_status_r <= 1'b0;
            sys_reset_r <= 1'b0;
            link_clock_select_r <= `RST_CLKSEL;
            system_clock_request_r <= 1'b1;
            program_start_r <= 1'b0;
            link_disabled_r <= 1'b0;
            nack_send_o <= 1'b0;
            user_row_done_o <= 1'b0;
            urow_session_reset_o <= 1'b0;
        end else if (ce_i) begin
            nack_send_o <= 1'b0;
            user_row_done_o <= 1'b0;
            urow_session_reset_o <= 1'b0;
            // Error load wins over the read clear
            if (!link_disabled_r && err_nxt != `ERR_NONE) begin
                error_signature_r <= err_nxt;
            end else if (csr_rd_i && csr_addr_i == `OFS_LINK_ERROR_STATUS) begin
                error_signature_r <= `ERR_NONE;
            end
            if (disable_w) begin
                // Configuration and keys return to defaults, except the system clock request, which clears to 0; reset request untouched
                ctrl_pri_r <= `RST_CONTROL;
                guard_sel_r <= 3'h0;
                ctrl_sec_r <= `RST_CONTROL;
                error_signature_r <= `ERR_NONE;
                user_row_key_status_r <= 1'b0;
                mem_program_key_status_r <= 1'b0;
                chip_erase_key_status_r <= 1'b0;
                link_clock_select_r <= `RST_CLKSEL;
                system_clock_request_r <= 1'b0;
                program_start_r <= 1'b0;
                link_disabled_r <= 1'b1;
            end else if (link_disabled_r) begin
                if (link_wake_i) begin
                    link_disabled_r <= 1'b0;
                    system_clock_request_r <= 1'b1;
                    link_clock_select_r <= `RST_CLKSEL;
                end
            end else begin
                if (wr_pri_w) begin
                    ctrl_pri_r <= {csr_wdata_i[7], 1'b0, csr_wdata_i[5:3], 3'h0};
                    if (csr_wdata_i[2:0] != `GUARD_RESERVED) begin
                        guard_sel_r <= csr_wdata_i[2:0];
                    end
                end
                if (wr_sec_w) begin
                    ctrl_sec_r <= {3'h0, csr_wdata_i[4:3], 3'h0};
                end
                if (wr_clk_w) begin
                    link_clock_select_r <= csr_wdata_i[1:0];
                end
                if (wr_sys_w) begin
                    system_clock_request_r <= csr_wdata_i[`SYS_SYSTEM_CLOCK_REQUEST_BIT];
                    if (csr_wdata_i[`SYS_USER_ROW_DONE_BIT] && user_row_key_status_r) begin
                        user_row_done_o <= 1'b1;
                    end
                end
                // Reserved codes leave the reset state as it is
                if (reset_assert_w) begin
                    sys_reset_r <= 1'b1;
                    program_start_r <= 1'b0;
                    if (ldst_busy_i && !ctrl_sec_r[`SEC_NEG_ACK_DISABLE_BIT] && !sys_reset_r) begin
                        nack_send_o <= 1'b1;
                    end
                end else if (reset_release_w) begin
                    sys_reset_r <= 1'b0;
                end
                // Key set on decode wins over its clear
                if (key_urow_ok_i) begin
                    user_row_key_status_r <= 1'b1;
                end else if (wr_key_w) begin
                    user_row_key_status_r <= 1'b0;
                    urow_session_reset_o <= 1'b1;
                end
                if (key_prog_ok_i) begin
                    mem_program_key_status_r <= 1'b1;
                end else if (reset_release_w && sys_reset_r && mem_program_key_status_r) begin
                    mem_program_key_status_r <= 1'b0;
                    program_start_r <= 1'b1;
                end
                if (key_erase_ok_i) begin
                    chip_erase_key_status_r <= 1'b1;
                end else if (reset_assert_w) begin
                    chip_erase_key_status_r <= 1'b0;
                end
            end
        end
    end

    // ==========================================================
    // Read port
    always @* begin
        rdata_nxt = 8'h00;
        case (csr_addr_i)
            `OFS_LINK_STATUS_REVISION: rdata_nxt = {LINK_REVISION, 4'h0};
            `OFS_LINK_ERROR_STATUS: rdata_nxt = {5'h00, error_signature_r};
            `OFS_LINK_CONTROL_PRIMARY: rdata_nxt = ctrl_pri_r | {5'h00, guard_sel_r};
            `OFS_LINK_CONTROL_SECONDARY: rdata_nxt = ctrl_sec_r;
            `OFS_KEY_STATUS: rdata_nxt = {2'h0, user_row_key_status_r,
                                          mem_program_key_status_r,
                                          chip_erase_key_status_r, 3'h0};
            `OFS_SYSTEM_RESET_REQUEST: rdata_nxt = sys_reset_r ? `RESET_CODE_ASSERT :
                                                                 `RESET_CODE_RELEASE;
            `OFS_LINK_CLOCK_CONTROL: rdata_nxt = {6'h00, link_clock_select_r};
            `OFS_SYSTEM_CONTROL: rdata_nxt = {7'h00, system_clock_request_r};
            default: rdata_nxt = 8'h00;
        endcase
    end

    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            csr_rdata_o <= 8'h00;
            csr_rvalid_o <= 1'b0;
        end else if (ce_i) begin
            csr_rvalid_o <= csr_rd_i;
            if (csr_rd_i) begin
                csr_rdata_o <= rdata_nxt;
            end
        end
    end

    // ==========================================================
    // Outputs
    assign link_enable_o = !link_disabled_r;
    assign resp_sig_en_o = !ctrl_pri_r[`PRI_RSD_BIT];
    // The reset output drives only the system; this block has no path from it
    assign system_reset_o = sys_reset_r;
    assign link_clock_select_o = link_clock_select_r;
    assign system_clock_request_o = system_clock_request_r && !link_disabled_r;
    assign program_start_status_o = program_start_r;
endmodule

// ### test/debug_link_regs_chk.sv
// Purpose: Port checks of the debug link control register block
// Assumes: One clock domain, asynchronous active-low reset
// Notes: Bound to every instance of the block
// ==========================================================
// Checker
module debug_link_regs_chk (
    input logic clk_sys_i,
    input logic rst_n_i,
    input logic ce_i,
    input logic csr_wr_i,
    input logic csr_rd_i,
    input logic [3:0] csr_addr_i,
    input logic [7:0] csr_wdata_i,
    input logic csr_rvalid_o,
    input logic rx_to_tx_i,
    input logic link_enable_o,
    input logic tx_hold_o,
    input logic resp_sig_en_o,
    input logic system_reset_o,
    input logic [1:0] link_clock_select_o,
    input logic system_clock_request_o,
    input logic user_row_done_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    // Write taken while the link is enabled
    wire w = ce_i && csr_wr_i && link_enable_o;
    AST_RVALID: assert property (ce_i && csr_rd_i |=> csr_rvalid_o)
        else $error("read not answered");
    AST_NO_RVALID: assert property (ce_i && !csr_rd_i |=> !csr_rvalid_o)
        else $error("answer without read");
    AST_RST_SET: assert property (w && csr_addr_i == 4'h8 && csr_wdata_i == 8'h59
        |=> system_reset_o) else $error("reset code did not assert");
    AST_RST_CLR: assert property (w && csr_addr_i == 4'h8 && csr_wdata_i == 8'h00
        |=> !system_reset_o) else $error("release code did not release");
    AST_RST_RSVD: assert property (w && csr_addr_i == 4'h8 && csr_wdata_i != 8'h59
        && csr_wdata_i != 8'h00 |=> $stable(system_reset_o)) else $error("reserved code acted");
    AST_CLKSEL: assert property (w && csr_addr_i == 4'h9
        |=> link_clock_select_o == $past(csr_wdata_i[1:0])) else $error("clock select wrong");
    AST_RSD: assert property (w && csr_addr_i == 4'h2
        |=> resp_sig_en_o != $past(csr_wdata_i[3])) else $error("signature enable wrong");
    AST_DISABLE: assert property (w && csr_addr_i == 4'h3 && csr_wdata_i[2]
        |=> !link_enable_o && !system_clock_request_o) else $error("disable incomplete");
    AST_SYSTEM_CLOCK_REQUEST: assert property (w && csr_addr_i == 4'ha
        |=> system_clock_request_o == $past(csr_wdata_i[0])) else $error("clock request wrong");
    AST_DONE: assert property (w && csr_addr_i == 4'ha && !csr_wdata_i[1]
        |=> !user_row_done_o) else $error("done without request");
    AST_GUARD: assert property (ce_i && rx_to_tx_i && link_enable_o
        |=> tx_hold_o [*2]) else $error("guard time too short");
endmodule
bind debug_link_control_regs debug_link_regs_chk u_debug_link_regs_chk (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .csr_wr_i(csr_wr_i),
    .csr_rd_i(csr_rd_i), .csr_addr_i(csr_addr_i), .csr_wdata_i(csr_wdata_i),
    .csr_rvalid_o(csr_rvalid_o), .rx_to_tx_i(rx_to_tx_i), .link_enable_o(link_enable_o),
    .tx_hold_o(tx_hold_o), .resp_sig_en_o(resp_sig_en_o), .system_reset_o(system_reset_o),
    .link_clock_select_o(link_clock_select_o), .system_clock_request_o(system_clock_request_o),
    .user_row_done_o(user_row_done_o));

// ### test/debug_link_far_end.sv
// Purpose: Far side of the link: link and bit ticks, pin with pull-up
// Assumes: Ticks derived from the system clock
// Notes: A clash is only made when the bench commands it
// ==========================================================
// Model
module debug_link_far_end (
    input logic clk_sys_i,
    input logic rst_n_i,
    input logic tx_drive_i,
    input logic tx_level_i,
    input logic clash_i,
    output logic link_tick_o,
    output logic bit_tick_o,
    output logic link_pin_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] div_r;
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_r <= 2'h0;
        end else begin
            div_r <= div_r + 2'h1;
        end
    end
    // Link cycle every second clock, bit period every fourth
    assign link_tick_o = div_r[0];
    assign bit_tick_o = (div_r == 2'h3);
    // Pull-up when released; a clash drives against the block
    assign link_pin_o = !tx_drive_i ? 1'b1 : (clash_i ? !tx_level_i : tx_level_i);
endmodule

// ### test/tb_debug_link_control_regs.sv
// Purpose: Self-checking bench of the debug link control registers
// Assumes: Far-end model supplies ticks and the pin
// Notes: Short timeout parameter keeps the run brief
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
    $display("BAD %0t got %h exp %h", $time, a, b); end end
module tb_debug_link_control_regs;
    timeunit 1ns;
    timeprecision 100ps;
    localparam [3:0] REV = 4'h2; // Arbitrary revision value
    localparam TMO = 8;
    logic clk_sys_i = 0, rst_n_i = 0, ce_i = 1, wr = 0, rd = 0, acc_wait = 0, mload = 0;
    logic ldst = 0, drive = 0, level = 0, clash = 0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic [9:0] ev = 10'h000;
    logic [31:0] seed = 32'h0000001c;
    int n_fail = 0, cmp_count = 0;
    wire [7:0] rdata;
    wire [1:0] cksel;
    wire rvalid, en, hold, rse, nack, sysrst, ckreq, done, sess, pstart, lt, bt, pin;
    debug_link_control_regs #(.LINK_REVISION(REV), .TIMEOUT_CYCLES(TMO)) u_debug_link_control_regs (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .csr_wr_i(wr), .csr_rd_i(rd),
        .csr_addr_i(addr), .csr_wdata_i(wdata), .csr_rdata_o(rdata), .csr_rvalid_o(rvalid),
        .link_wake_i(ev[9]), .link_tick_i(lt), .bit_tick_i(bt), .parity_err_i(ev[0]),
        .frame_err_i(ev[1]), .start_err_i(ev[2]), .bus_err_i(ev[3]), .acc_wait_i(acc_wait),
        .rx_to_tx_i(ev[4]), .multi_load_i(mload), .tx_byte_done_i(ev[5]), .ldst_busy_i(ldst),
        .tx_drive_i(drive), .tx_level_i(level), .link_pin_i(pin), .key_urow_ok_i(ev[6]),
        .key_prog_ok_i(ev[7]), .key_erase_ok_i(ev[8]), .link_enable_o(en), .tx_hold_o(hold),
        .resp_sig_en_o(rse), .nack_send_o(nack), .system_reset_o(sysrst),
        .link_clock_select_o(cksel), .system_clock_request_o(ckreq), .user_row_done_o(done),
        .urow_session_reset_o(sess), .program_start_status_o(pstart));
    debug_link_far_end u_debug_link_far_end (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .tx_drive_i(drive), .tx_level_i(level), .clash_i(clash), .link_tick_o(lt),
        .bit_tick_o(bt), .link_pin_o(pin));
    // ==========================================================
    // Helpers
    function logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    function automatic logic [7:0] rst_val(input logic [3:0] a);
        case (a)
            4'h0: return {REV, 4'h0};
            4'h9: return 8'h03;
            4'ha: return 8'h01;
            default: return 8'h00;
        endcase
    endfunction
    function automatic logic [7:0] wr_val(input logic [3:0] a, input logic [7:0] d);
        case (a)
            4'h0: return {REV, 4'h0};
            4'h2: return d & 8'hbf;
            4'h3: return d & 8'h18;
            4'h9: return d & 8'h03;
            default: return 8'h00;
        endcase
    endfunction
    task automatic step();
        @(posedge clk_sys_i);
        #2;
    endtask
    task automatic wrt(input logic [3:0] a, input logic [7:0] d);
        step();
        {wr, addr, wdata} = {1'b1, a, d};
        step();
        wr = 0;
    endtask
    task automatic rc(input logic [3:0] a, input logic [7:0] e);
        step();
        {rd, addr} = {1'b1, a};
        step();
        rd = 0;
        `CHK(rvalid, 1'b1)
        `CHK(rdata, e)
    endtask
    task automatic pulse(input int i);
        step();
        ev[i] = 1;
        step();
        ev[i] = 0;
    endtask
    task automatic hold_cnt(input bit use_bit, input int e);
        int n = 0;
        // Count the ticks taken at the next edge while hold stands, sampled off the edge
        for (int k = 0; k < 400 && hold; k++) begin
            n += use_bit ? bt : lt;
            step();
        end
        if (hold) begin
            n_fail++;
            give_verdict();
        end else `CHK(n, e)
    endtask
    task automatic clash_run(input logic c);
        {drive, clash} = {1'b1, c};
        repeat (8) step();
        {drive, clash} = 2'b00;
        repeat (4) step();
    endtask
    task automatic give_verdict();
        if (n_fail == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ==========================================================
    // Clock, watchdog and sequence
    initial forever #12.5 clk_sys_i = ~clk_sys_i;
    initial begin
        repeat (60000) @(posedge clk_sys_i);
        n_fail++;
        give_verdict();
    end
    initial begin
        logic [3:0] amap [6];
        logic [3:0] a;
        logic [7:0] d;
        logic [2:0] ecode [4];
        amap = '{4'h2, 4'h3, 4'h9, 4'h4, 4'hb, 4'h0};
        ecode = '{3'h1, 3'h2, 3'h4, 3'h6};
        repeat (20) step();
        rst_n_i = 1;
        `CHK({rse, cksel, ckreq, sysrst}, 5'b11110)
        for (int i = 0; i < 16; i++) rc(i[3:0], rst_val(i[3:0]));
        for (int i = 0; i < 24; i++) begin
            a = amap[rnd() % 6];
            d = rnd();
            if (a == 4'h3) d[2] = 0;
            if (a == 4'h2 && d[2:0] == 3'h7) d[0] = 0;
            wrt(a, d);
            rc(a, wr_val(a, d));
            if (a == 4'h9) `CHK(cksel, d[1:0])
        end
        wrt(4'h2, 8'h05);
        wrt(4'h2, 8'h27);
        rc(4'h2, 8'h25);
        wrt(4'h3, 8'h00);
        wrt(4'h9, 8'h01);
        ce_i = 0;
        wrt(4'h9, 8'h02);
        ce_i = 1;
        rc(4'h9, 8'h01);
        wrt(4'h2, 8'h08);
        `CHK(rse, 1'b0)
        for (int i = 0; i < 4; i++) begin
            pulse(i);
            rc(4'h1, {5'h00, ecode[i]});
            rc(4'h1, 8'h00);
        end
        wrt(4'h2, 8'h20);
        pulse(0);
        rc(4'h1, 8'h00);
        wrt(4'h2, 8'h00);
        acc_wait = 1;
        repeat (2 * TMO + 10) step();
        acc_wait = 0;
        rc(4'h1, 8'h03);
        wrt(4'h2, 8'h10);
        acc_wait = 1;
        repeat (2 * TMO + 10) step();
        acc_wait = 0;
        rc(4'h1, 8'h00);
        clash_run(1);
        rc(4'h1, 8'h07);
        clash_run(0);
        rc(4'h1, 8'h00);
        wrt(4'h3, 8'h08);
        clash_run(1);
        rc(4'h1, 8'h00);
        for (int g = 0; g < 7; g++) begin
            wrt(4'h2, g[7:0]);
            pulse(4);
            hold_cnt(0, 128 >> g);
        end
        wrt(4'h2, 8'h80);
        mload = 1;
        pulse(5);
        hold_cnt(1, 2);
        wrt(4'h2, 8'h00);
        pulse(5);
        `CHK(hold, 1'b0)
        mload = 0;
        ldst = 1;
        wrt(4'h8, 8'h59);
        `CHK({sysrst, nack}, 2'b11)
        wrt(4'h8, 8'h33);
        rc(4'h8, 8'h59);
        rc(4'h9, 8'h01);
        `CHK({sysrst, en}, 2'b11)
        wrt(4'h8, 8'h00);
        wrt(4'h8, 8'h5a);
        `CHK(sysrst, 1'b0)
        wrt(4'h3, 8'h10);
        wrt(4'h8, 8'h59);
        `CHK(nack, 1'b0)
        wrt(4'h8, 8'h00);
        ldst = 0;
        pulse(7);
        rc(4'h7, 8'h10);
        wrt(4'h8, 8'h59);
        wrt(4'h8, 8'h00);
        rc(4'h7, 8'h00);
        `CHK(pstart, 1'b1)
        pulse(8);
        rc(4'h7, 8'h08);
        wrt(4'h8, 8'h59);
        rc(4'h7, 8'h00);
        wrt(4'h8, 8'h00);
        wrt(4'ha, 8'h03);
        `CHK(done, 1'b0)
        pulse(6);
        rc(4'h7, 8'h20);
        wrt(4'ha, 8'h03);
        `CHK(done, 1'b1)
        wrt(4'h7, 8'h20);
        `CHK(sess, 1'b1)
        rc(4'h7, 8'h00);
        wrt(4'h2, 8'h80);
        wrt(4'h3, 8'h04);
        `CHK({en, ckreq}, 2'b00)
        wrt(4'h9, 8'h00);
        rc(4'h2, 8'h00);
        rc(4'h9, 8'h03);
        pulse(9);
        `CHK({en, ckreq}, 2'b11)
        give_verdict();
    end
endmodule
